// ===== core/smmc_ctrl.sv
// Purpose: Supply monitor and margin control with AXI4-Lite registers.
// Assumes: Pins are asynchronous to clk; margin_sense_input comes from on-chip ADC logic on clk.
// Notes:   Open-drain pins are driven low when their enable (active low) is low.
//
// Summary of operation
// - Each sense input is set separately to watch for under_voltage or over_voltage.
// - Fault pin is pulled low while either filtered sense input is in fault.
// - Ready pin polarity is selectable; it shows that the sense code reached target.
// - With ready active high, an outside low on ready captures both sense states.
// - Two status bits show the live sense states, one meaning fault.
// - Two status bits hold latched states; capture source is fault pin or ready pin.
// - High and low targets are stored and copied to the active target on command.
// - A two-bit command field selects margin off, nominal, high or low.
// - Trim steps toward target; on reaching it the reached bit and ready assert.
// - Optional suppression of the fault pin in margin states other than off and nominal.
// - Hold-off and shutdown request works only in the nominal margin state.
// - Fault-pin capture acts on the leading edge only, so a clear sticks.
// - Ready-pin capture mode also latches on listed margin transitions, never into off.
// - Write protection is volatile and starts protected for configuration and memory.
// - Code 55 hex removes both protections; other codes protect at least one region.
// - Code 59 hex opens configuration only, code 35 hex opens memory only.
// - The write-lock pin blocks configuration and memory writes while asserted.
// - Once the configuration lock bit is set, configuration writes are refused.
// - Each address pin reads high, low or floating, giving 21 device addresses.
// - Upper nibble 0101 opens configuration, lower nibble 0101 opens memory.
// - The write-only protection register sits at offset 38 hex.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "smmc_defines.svh"

module smmc_ctrl #(
    parameter int unsigned GLITCH_40_CYC  = `SMMC_GLITCH_40_US * `SMMC_CLK_MHZ,
    parameter int unsigned GLITCH_120_CYC = `SMMC_GLITCH_120_US * `SMMC_CLK_MHZ,
    parameter int unsigned STEP_CYC       = `SMMC_STEP_US * `SMMC_CLK_MHZ
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire smmc_pkg::smmc_axi_req_t axi_req,
    output      smmc_pkg::smmc_axi_rsp_t axi_rsp,
    input  wire smmc_pkg::smmc_pin_in_t  pins_in,
    input  wire logic [7:0]              margin_sense_input,
    output      smmc_pkg::smmc_pin_out_t pins_out
);
    import smmc_pkg::*;

    localparam int unsigned GLITCH_15_CYC = `SMMC_GLITCH_15_US * `SMMC_CLK_MHZ;

    smmc_state_t      st_reg;
    smmc_state_t      st_next;
    logic [1:0]       raw;
    logic [1:0][15:0] lim;
    logic             wr_fire;
    logic             rd_fire;
    logic [7:0]       waddr;
    logic [7:0]       raddr;
    logic             cfg_ok;
    logic             mem_ok;
    logic             cmd_wr;
    smmc_mstate_t     cmd_state;
    logic             ev_trans;
    logic             ev_pin;
    logic             ev_fault;
    logic             lat_clr;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] glitch_limit(input logic [1:0] sel);
        case (sel)
            2'd0:    glitch_limit = 16'h0000;
            2'd1:    glitch_limit = 16'(GLITCH_15_CYC);
            2'd2:    glitch_limit = 16'(GLITCH_40_CYC);
            default: glitch_limit = 16'(GLITCH_120_CYC);
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                old[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = old;
    endfunction

    function automatic logic [1:0] tri_code(input logic flt, input logic lvl);
        tri_code = flt ? 2'b10 : {1'b0, lvl};
    endfunction

    function automatic logic trans_ok(input smmc_mstate_t from, input smmc_mstate_t to);
        trans_ok = (to != MS_OFF) && (from != to) &&
                   ((from == MS_OFF) || (from == MS_NOMINAL) || (to == MS_NOMINAL));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // The comparator is high above the reference; the polarity bit picks which side faults.
    assign raw       = ~(st_reg.sense_s2 ^ st_reg.cfg[`SMMC_CFG_POL_TWO:`SMMC_CFG_POL_ONE]);
    assign lim[0]    = glitch_limit(st_reg.cfg[`SMMC_CFG_GSEL_ONE]);
    assign lim[1]    = glitch_limit(st_reg.cfg[`SMMC_CFG_GSEL_TWO]);
    assign wr_fire   = axi_req.awvalid && axi_req.wvalid && !st_reg.bvalid;
    assign rd_fire   = axi_req.arvalid && !st_reg.rvalid;
    assign waddr     = axi_req.awaddr[7:0];
    assign raddr     = axi_req.araddr[7:0];
    // Code 59 hex opens configuration and 35 hex opens memory, so the high nibble guards configuration.
    assign cfg_ok    = (st_reg.wprot[7:4] == `SMMC_WP_UNLOCK) && !st_reg.wlock_s2
                       && !st_reg.cfg[`SMMC_CFG_LOCK];
    assign mem_ok    = (st_reg.wprot[3:0] == `SMMC_WP_UNLOCK) && !st_reg.wlock_s2;
    assign cmd_wr    = wr_fire && (waddr == `SMMC_OFS_MARG_CMD) && axi_req.wstrb[0];
    assign cmd_state = smmc_mstate_t'(axi_req.wdata[1:0]);
    assign ev_trans  = cmd_wr && st_reg.cfg[`SMMC_CFG_LATCH_RDY] && trans_ok(st_reg.mstate, cmd_state);
    assign ev_pin    = st_reg.cfg[`SMMC_CFG_LATCH_RDY] && st_reg.cfg[`SMMC_CFG_RDY_HIGH]
                       && st_reg.ready_prev && !st_reg.ready_s2 && !st_reg.ready_drive;
    assign ev_fault  = !st_reg.cfg[`SMMC_CFG_LATCH_RDY] && st_reg.fault_drive && !st_reg.fault_prev;
    assign lat_clr   = wr_fire && (waddr == `SMMC_OFS_STATUS) && axi_req.wstrb[0];

    assign axi_rsp.awready = wr_fire;
    assign axi_rsp.wready  = wr_fire;
    assign axi_rsp.bvalid  = st_reg.bvalid;
    assign axi_rsp.bresp   = st_reg.bresp;
    assign axi_rsp.arready = rd_fire;
    assign axi_rsp.rvalid  = st_reg.rvalid;
    assign axi_rsp.rdata   = st_reg.rdata;
    assign axi_rsp.rresp   = st_reg.rresp;

    assign pins_out.fault_out    = 1'b0;
    assign pins_out.fault_oe_n   = !st_reg.fault_drive;
    assign pins_out.ready_out    = 1'b0;
    assign pins_out.ready_oe_n   = !st_reg.ready_drive;
    assign pins_out.trim_code    = st_reg.trim;
    assign pins_out.trim_oe_n    = !st_reg.drive;
    assign pins_out.shutdown_req = st_reg.shutdown;
    assign pins_out.device_addr  = st_reg.devaddr;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;

        // Every pin passes two flops before any logic looks at it.
        st_next.sense_s1 = {pins_in.sense_input_two, pins_in.sense_input_one};
        st_next.sense_s2 = st_reg.sense_s1;
        st_next.ready_s1 = pins_in.ready_in;
        st_next.ready_s2 = st_reg.ready_s1;
        st_next.ready_prev = st_reg.ready_s2;
        st_next.wlock_s1 = pins_in.write_lock;
        st_next.wlock_s2 = st_reg.wlock_s1;
        st_next.alev_s1 = pins_in.addr_level;
        st_next.alev_s2 = st_reg.alev_s1;
        st_next.aflt_s1 = pins_in.addr_float;
        st_next.aflt_s2 = st_reg.aflt_s1;

        st_next.devaddr[6:3] = {2'b10, tri_code(st_reg.aflt_s2[2], st_reg.alev_s2[2])};
        if (st_reg.aflt_s2[1]) begin
            st_next.devaddr[2:0] = 3'b011;
        end else begin
            st_next.devaddr[2:0] = {st_reg.alev_s2[1], tri_code(st_reg.aflt_s2[0], st_reg.alev_s2[0])};
        end

        // A zero limit passes a change on at once; otherwise it must stand for the full count.
        for (int i = 0; i < 2; i++) begin
            if (raw[i] == st_reg.filt[i]) begin
                st_next.gcnt[i] = 16'h0000;
            end else if ({1'b0, st_reg.gcnt[i]} + 17'h00001 >= {1'b0, lim[i]}) begin
                st_next.filt[i] = raw[i];
                st_next.gcnt[i] = 16'h0000;
            end else begin
                st_next.gcnt[i] = st_reg.gcnt[i] + 16'h0001;
            end
        end

        st_next.fault_prev  = st_reg.fault_drive;
        st_next.fault_drive = (|st_reg.filt) && !(st_reg.cfg[`SMMC_CFG_FLT_MDIS] &&
                              ((st_reg.mstate == MS_HIGH) || (st_reg.mstate == MS_LOW)));
        st_next.shutdown    = st_reg.cfg[`SMMC_CFG_HOLDOFF] && (st_reg.mstate == MS_NOMINAL)
                              && (|st_reg.filt);
        st_next.ready_drive = st_reg.cfg[`SMMC_CFG_RDY_HIGH] ? !st_reg.reached : st_reg.reached;

        // Trim moves one code per step period toward the target.
        if (st_reg.drive) begin
            if (margin_sense_input == st_reg.target) begin
                st_next.reached = 1'b1;
                st_next.step = 16'h0000;
            end else if ({16'h0000, st_reg.step} + 32'h1 >= 32'(STEP_CYC)) begin
                st_next.step = 16'h0000;
                if (margin_sense_input < st_reg.target) begin
                    st_next.trim = st_reg.trim + 8'h01;
                end else begin
                    st_next.trim = st_reg.trim - 8'h01;
                end
            end else begin
                st_next.step = st_reg.step + 16'h0001;
            end
        end

        // Register writes.
        if (wr_fire) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = `SMMC_RESP_OKAY;
            if (waddr == `SMMC_OFS_CONFIG) begin
                if (cfg_ok) begin
                    st_next.cfg = 11'(merge({21'h0, st_reg.cfg}, axi_req.wdata, axi_req.wstrb));
                    st_next.cfg[`SMMC_CFG_LOCK] = st_next.cfg[`SMMC_CFG_LOCK] | st_reg.cfg[`SMMC_CFG_LOCK];
                end else begin
                    st_next.bresp = `SMMC_RESP_SLVERR;
                end
            end else if ((waddr == `SMMC_OFS_MARG_HIGH) || (waddr == `SMMC_OFS_MARG_LOW)
                         || (waddr == `SMMC_OFS_MARG_NOM)) begin
                if (cfg_ok && axi_req.wstrb[0]) begin
                    case (waddr)
                        `SMMC_OFS_MARG_HIGH: st_next.mhigh = axi_req.wdata[7:0];
                        `SMMC_OFS_MARG_LOW:  st_next.mlow = axi_req.wdata[7:0];
                        default:             st_next.mnom = axi_req.wdata[7:0];
                    endcase
                end else if (!cfg_ok) begin
                    st_next.bresp = `SMMC_RESP_SLVERR;
                end
            end else if (waddr == `SMMC_OFS_MARG_CMD) begin
                if (cmd_wr) begin
                    st_next.mstate = cmd_state;
                    st_next.reached = 1'b0;
                    st_next.step = 16'h0000;
                    st_next.drive = (cmd_state != MS_OFF);
                    case (cmd_state)
                        MS_HIGH:    st_next.target = st_reg.mhigh;
                        MS_LOW:     st_next.target = st_reg.mlow;
                        MS_NOMINAL: st_next.target = st_reg.mnom;
                        default:    st_next.target = st_reg.target;
                    endcase
                    // Starting from off, trim begins at the nominal code so the supply does not jump.
                    if (st_reg.mstate == MS_OFF) begin
                        st_next.trim = st_reg.mnom;
                    end
                end
            end else if (waddr == `SMMC_OFS_STATUS) begin
                st_next.bresp = `SMMC_RESP_OKAY;
            end else if (waddr == `SMMC_OFS_WPROT) begin
                if (axi_req.wstrb[0]) begin
                    st_next.wprot = axi_req.wdata[7:0];
                end
            end else if (waddr[7:5] == `SMMC_MEM_BASE_HI) begin
                if (mem_ok) begin
                    st_next.mem[waddr[4:2]] = merge(st_reg.mem[waddr[4:2]], axi_req.wdata, axi_req.wstrb);
                end else begin
                    st_next.bresp = `SMMC_RESP_SLVERR;
                end
            end else begin
                st_next.bresp = `SMMC_RESP_SLVERR;
            end
        end else if (st_reg.bvalid && axi_req.bready) begin
            st_next.bvalid = 1'b0;
        end

        // Clear first, then capture, so an event in the clearing cycle survives.
        if (lat_clr) begin
            st_next.latched = st_reg.latched & ~axi_req.wdata[`SMMC_ST_LATCHED];
        end
        if (ev_fault || ev_pin || ev_trans) begin
            st_next.latched = st_next.latched | st_reg.filt;
        end

        // Register reads; the protection register is write-only and reads zero.
        if (rd_fire) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `SMMC_RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            case (raddr)
                `SMMC_OFS_CONFIG:    st_next.rdata = {21'h0, st_reg.cfg};
                `SMMC_OFS_MARG_HIGH: st_next.rdata = {24'h0, st_reg.mhigh};
                `SMMC_OFS_MARG_LOW:  st_next.rdata = {24'h0, st_reg.mlow};
                `SMMC_OFS_MARG_NOM:  st_next.rdata = {24'h0, st_reg.mnom};
                `SMMC_OFS_MARG_CMD:  st_next.rdata = {30'h0, st_reg.mstate};
                `SMMC_OFS_STATUS:    st_next.rdata = {25'h0, st_reg.mstate, st_reg.reached,
                                                      st_reg.latched, st_reg.filt};
                `SMMC_OFS_DEV_ADDR:  st_next.rdata = {25'h0, st_reg.devaddr};
                `SMMC_OFS_WPROT:     st_next.rdata = 32'h0000_0000;
                default: begin
                    if (raddr[7:5] == `SMMC_MEM_BASE_HI) begin
                        st_next.rdata = st_reg.mem[raddr[4:2]];
                    end else begin
                        st_next.rresp = `SMMC_RESP_SLVERR;
                    end
                end
            endcase
        end else if (st_reg.rvalid && axi_req.rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.wprot <= `SMMC_WP_RESET;
            // Syncs start at the idle pin levels, so no false fault or ready edge is latched after reset.
            st_reg.sense_s1 <= 2'b11;
            st_reg.sense_s2 <= 2'b11;
            st_reg.ready_s1 <= 1'b1;
            st_reg.ready_s2 <= 1'b1;
            st_reg.ready_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_fault_pin_drive: assert property (@(posedge clk) disable iff (reset)
        ((|st_reg.filt) && !st_reg.cfg[`SMMC_CFG_FLT_MDIS]) |=> !pins_out.fault_oe_n)
        else $error("Fault pin not driven while a sense input is in fault.");

    a_fault_margin_off: assert property (@(posedge clk) disable iff (reset)
        (st_reg.cfg[`SMMC_CFG_FLT_MDIS] && (st_reg.mstate == MS_HIGH || st_reg.mstate == MS_LOW))
        |=> pins_out.fault_oe_n)
        else $error("Fault pin driven while margining with suppression on.");

    a_shutdown_nominal: assert property (@(posedge clk) disable iff (reset)
        pins_out.shutdown_req |-> $past(st_reg.mstate) == MS_NOMINAL)
        else $error("Shutdown request outside the nominal state.");

    a_wprot_powerup: assert property (@(posedge clk)
        $fell(reset) |-> (st_reg.wprot == 8'h00 && !cfg_ok && !mem_ok))
        else $error("Write protection not set after reset.");

    a_code_unlock: assert property (@(posedge clk) disable iff (reset)
        (wr_fire && waddr == `SMMC_OFS_WPROT && axi_req.wstrb[0] && axi_req.wdata[7:0] == 8'h55
         && !st_reg.wlock_s2 && !st_reg.wlock_s1 && !st_reg.cfg[`SMMC_CFG_LOCK]) |=> (cfg_ok && mem_ok))
        else $error("Code 55 did not open both regions.");

    a_cfg_protected: assert property (@(posedge clk) disable iff (reset)
        (wr_fire && waddr == `SMMC_OFS_CONFIG && st_reg.wprot[7:4] != 4'h5) |=> $stable(st_reg.cfg))
        else $error("Configuration changed while protected.");

    a_wlock_blocks: assert property (@(posedge clk) disable iff (reset)
        (wr_fire && st_reg.wlock_s2 && waddr[7:5] == `SMMC_MEM_BASE_HI) |=> ($stable(st_reg.mem) && axi_rsp.bresp == 2'b10))
        else $error("Memory written while the write-lock pin is asserted.");

    a_lock_sticky: assert property (@(posedge clk) disable iff (reset)
        st_reg.cfg[`SMMC_CFG_LOCK] |=> (st_reg.cfg[`SMMC_CFG_LOCK] && $stable(st_reg.cfg)))
        else $error("Locked configuration changed.");

    a_fault_capture: assert property (@(posedge clk) disable iff (reset)
        ev_fault |=> ((st_reg.latched & $past(st_reg.filt)) == $past(st_reg.filt)))
        else $error("Leading fault edge not captured.");

    a_margin_reach: assert property (@(posedge clk) disable iff (reset)
        (st_reg.drive && margin_sense_input == st_reg.target && !cmd_wr) |=> st_reg.reached ##1
        (pins_out.ready_oe_n == st_reg.cfg[`SMMC_CFG_RDY_HIGH]))
        else $error("Target reached without reached bit or ready.");

    a_filter_bypass: assert property (@(posedge clk) disable iff (reset)
        (st_reg.cfg[`SMMC_CFG_GSEL_ONE] == 2'd0 && raw[0] != st_reg.filt[0]) |=> st_reg.filt[0] == $past(raw[0]))
        else $error("Bypassed filter did not pass the input at once.");

    a_addr_float: assert property (@(posedge clk) disable iff (reset)
        st_reg.aflt_s2[2] |=> (pins_out.device_addr[6:3] == 4'b1010))
        else $error("Floating top address pin decoded wrongly.");

endmodule
`default_nettype wire

// ===== inc/smmc_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the supply monitor margin control.
// Assumes: 200 MHz core clock, AXI4-Lite register access with byte addresses.
// Notes:   Counts above 4096 cycles are parameters of the top module instead.
`ifndef SMMC_DEFINES_SVH
`define SMMC_DEFINES_SVH

`define SMMC_CLK_MHZ        200
`define SMMC_GLITCH_15_US   15
`define SMMC_GLITCH_40_US   40
`define SMMC_GLITCH_120_US  120
`define SMMC_STEP_US        200

`define SMMC_OFS_CONFIG     8'h00
`define SMMC_OFS_MARG_HIGH  8'h04
`define SMMC_OFS_MARG_LOW   8'h08
`define SMMC_OFS_MARG_NOM   8'h0c
`define SMMC_OFS_MARG_CMD   8'h10
`define SMMC_OFS_STATUS     8'h14
`define SMMC_OFS_DEV_ADDR   8'h18
`define SMMC_OFS_WPROT      8'h38
`define SMMC_MEM_BASE_HI    3'b010

`define SMMC_CFG_POL_ONE    0
`define SMMC_CFG_POL_TWO    1
`define SMMC_CFG_RDY_HIGH   2
`define SMMC_CFG_LATCH_RDY  3
`define SMMC_CFG_FLT_MDIS   4
`define SMMC_CFG_HOLDOFF    5
`define SMMC_CFG_GSEL_ONE   7:6
`define SMMC_CFG_GSEL_TWO   9:8
`define SMMC_CFG_LOCK       10

`define SMMC_ST_LATCHED     3:2
`define SMMC_WP_UNLOCK      4'h5
`define SMMC_WP_RESET       8'h00
`define SMMC_RESP_OKAY      2'b00
`define SMMC_RESP_SLVERR    2'b10

`endif

// ===== inc/smmc_pkg.sv
// Purpose: Types shared by the supply monitor margin control and its bench.
// Assumes: Nothing beyond the defines header.
// Notes:   Margin state codes follow declaration order and match the command field.
package smmc_pkg;

    typedef enum logic [1:0] {MS_OFF, MS_NOMINAL, MS_HIGH, MS_LOW} smmc_mstate_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } smmc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } smmc_axi_rsp_t;

    typedef struct packed {
        logic       sense_input_one;
        logic       sense_input_two;
        logic       ready_in;
        logic       write_lock;
        logic [2:0] addr_level;
        logic [2:0] addr_float;
    } smmc_pin_in_t;

    typedef struct packed {
        logic       fault_out;
        logic       fault_oe_n;
        logic       ready_out;
        logic       ready_oe_n;
        logic [7:0] trim_code;
        logic       trim_oe_n;
        logic       shutdown_req;
        logic [6:0] device_addr;
    } smmc_pin_out_t;

    typedef struct packed {
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [10:0]       cfg;
        logic [7:0]        mhigh;
        logic [7:0]        mlow;
        logic [7:0]        mnom;
        logic [7:0]        wprot;
        smmc_mstate_t      mstate;
        logic [7:0]        target;
        logic [7:0]        trim;
        logic              drive;
        logic              reached;
        logic [15:0]       step;
        logic [1:0]        sense_s1;
        logic [1:0]        sense_s2;
        logic [1:0]        filt;
        logic [1:0][15:0]  gcnt;
        logic [1:0]        latched;
        logic              fault_drive;
        logic              fault_prev;
        logic              shutdown;
        logic              ready_drive;
        logic              ready_s1;
        logic              ready_s2;
        logic              ready_prev;
        logic              wlock_s1;
        logic              wlock_s2;
        logic [2:0]        alev_s1;
        logic [2:0]        alev_s2;
        logic [2:0]        aflt_s1;
        logic [2:0]        aflt_s2;
        logic [6:0]        devaddr;
        logic [7:0][31:0]  mem;
    } smmc_state_t;

endpackage

// ===== testbench/smmc_conv_model.sv
// Purpose: Converter model that returns the trimmed supply as a sense code.
// Assumes: The sense code follows the trim code one cycle later.
// Notes:   Rests at the nominal code while trim is released.
`timescale 1ns/1ps
`default_nettype none
module smmc_conv_model #(parameter logic [7:0] NOM = 8'h30) (
    input  wire logic       clk,
    input  wire logic [7:0] trim,
    input  wire logic       trim_oe_n,
    output var  logic [7:0] sense
);
    initial sense = NOM;
    always @(posedge clk) begin
        sense <= trim_oe_n ? NOM : trim;
    end
endmodule
`default_nettype wire

// ===== testbench/smmc_ctrl_tb.sv
// Purpose: Self-checking bench for the supply monitor margin control.
// Assumes: The 40 us and 120 us glitch counts and the step count are shortened by parameters; the 15 us count is not.
// Notes:   The ready pin has a pull-up, so its level is the device enable.
`timescale 1ns/1ps
`default_nettype none
module smmc_ctrl_tb;
    import smmc_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} smmc_row_t;
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    logic          s1 = 1'b1;
    logic          wl = 1'b0;
    logic [1:0]    r;
    logic [31:0]   d;
    logic [7:0]    sense;
    int            err_count = 0;
    int            n_compared = 0;
    smmc_axi_req_t req = '{wstrb: 4'hf, default: '0};
    smmc_axi_rsp_t rsp;
    smmc_pin_out_t po;
    wire smmc_pin_in_t pin = {s1, 1'b1, po.ready_oe_n, wl, 3'b010, 3'b101};
    localparam smmc_row_t ROWS [15] = '{
        {1'b1, 8'h00, 32'h1, 2'h2}, {1'b1, 8'h38, 32'h59, 2'h0},
        {1'b1, 8'h40, 32'h12, 2'h2}, {1'b1, 8'h00, 32'h1, 2'h0},
        {1'b0, 8'h00, 32'h1, 2'h0}, {1'b1, 8'h38, 32'h35, 2'h0},
        {1'b1, 8'h0c, 32'h30, 2'h2}, {1'b1, 8'h40, 32'h12, 2'h0},
        {1'b0, 8'h40, 32'h12, 2'h0}, {1'b1, 8'h38, 32'h55, 2'h0},
        {1'b1, 8'h0c, 32'h30, 2'h0}, {1'b1, 8'h04, 32'h40, 2'h0},
        {1'b0, 8'h38, 32'h0, 2'h0}, {1'b0, 8'h20, 32'h0, 2'h2},
        {1'b0, 8'h18, 32'h56, 2'h0}};
    always #2.5 clk = ~clk;
    smmc_ctrl #(.GLITCH_40_CYC(40), .GLITCH_120_CYC(60), .STEP_CYC(8)) DUT (.clk(clk), .reset(reset),
        .axi_req(req), .axi_rsp(rsp), .pins_in(pin), .margin_sense_input(sense), .pins_out(po));
    smmc_conv_model u_conv (.clk(clk), .trim(po.trim_code), .trim_oe_n(po.trim_oe_n), .sense(sense));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Both tasks start and end just after a rising edge, holding each channel until taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        req.awaddr <= {24'h0, a};
        req.wdata <= v;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do @(posedge clk); while (!(rsp.awready && rsp.wready));
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        req.araddr <= {24'h0, a};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        v = rsp.rdata;
        resp = rsp.rresp;
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (ROWS[i]) begin
            if (ROWS[i].w) begin
                axw(ROWS[i].a, ROWS[i].d, r);
            end else begin
                axr(ROWS[i].a, d, r);
                chk(d, ROWS[i].d);
            end
            chk(r, ROWS[i].r);
        end
        $display("register rows done");
        chk(po.fault_oe_n, 1'b0);
        axr(8'h14, d, r);
        chk(d, 32'h05);
        axw(8'h14, 32'h0c, r);
        axr(8'h14, d, r);
        chk(d, 32'h01);
        s1 <= 1'b0;
        repeat (8) @(posedge clk);
        chk(po.fault_oe_n, 1'b1);
        $display("fault test done");
        axw(8'h10, 32'h2, r);
        for (int i = 0; i < 600 && po.ready_oe_n !== 1'b0; i++) @(posedge clk);
        chk(po.ready_oe_n, 1'b0);
        chk(po.trim_code, 8'h40);
        chk(po.trim_oe_n, 1'b0);
        axr(8'h14, d, r);
        chk(d, 32'h50);
        axw(8'h10, 32'h0, r);
        repeat (2) @(posedge clk);
        chk(po.trim_oe_n, 1'b1);
        $display("margin test done");
        // Configuration is only rewritten while margining is off.
        axw(8'h00, 32'h8, r);
        repeat (8) @(posedge clk);
        axw(8'h10, 32'h1, r);
        axr(8'h14, d, r);
        chk(d, 32'h35);
        axw(8'h10, 32'h0, r);
        $display("transition latch test done");
        wl <= 1'b1;
        repeat (4) @(posedge clk);
        axw(8'h00, 32'h1, r);
        chk(r, 2'h2);
        axw(8'h40, 32'h1, r);
        chk(r, 2'h2);
        wl <= 1'b0;
        repeat (4) @(posedge clk);
        axw(8'h00, 32'h401, r);
        axw(8'h00, 32'h1, r);
        chk(r, 2'h2);
        $display("lock test done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        axr(8'h00, d, r);
        chk(d, 32'h0);
        axw(8'h00, 32'h1, r);
        chk(r, 2'h2);
        $display("reset test done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
